// [discrete_safe_selection_inputs_tb_top.sv]
// Purpose: Self-checking bench for the discrete safe selection inputs
// Assumes: Tolerance shortened to 20 cycles; pair 1 stays single-channel
// Notes: Inputs change 1 ns after the rising edge and outputs are checked there too
`timescale 1ns/1ps
`default_nettype none
`include "safe_sel_params.svh"
module discrete_safe_selection_inputs_tb_top;
	localparam int TOL = 20;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	safe_sel_pkg::input_vec_t cmd_n = 16'hffff;
	safe_sel_pkg::input_vec_t sel_in_n;
	// Mode must stay static, so it is fixed from time zero
	safe_sel_pkg::pair_vec_t pair_single = 8'h02;
	logic err_clear = 1'b0;
	logic [`SEL_AXIS_W-1:0] axis_count = 6'h01;
	logic ack_request = 1'b0;
	safe_sel_pkg::input_vec_t sel_active;
	safe_sel_pkg::pair_vec_t pair_fault;
	logic local_io_fault_message;
	logic axis_overflow;
	logic [1:0] zone_acknowledge;
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;
	always #4 ref_clk = ~ref_clk;
	sel_source_model sel_source_model_i (.ref_clk(ref_clk), .cmd_n(cmd_n), .sel_in_n(sel_in_n));
	safe_sel_inputs #(.TOL_CYCLES(`SEL_TMR_W'(TOL))) safe_sel_inputs_i (
		.ref_clk(ref_clk), .resetn(resetn), .sel_in_n(sel_in_n), .pair_single(pair_single),
		.err_clear(err_clear), .axis_count(axis_count), .ack_request(ack_request),
		.sel_active(sel_active), .pair_fault(pair_fault),
		.local_io_fault_message(local_io_fault_message), .axis_overflow(axis_overflow),
		.zone_acknowledge(zone_acknowledge));
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic chk(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic t_dual;
		cmd_n[1:0] = 2'h0;
		wt(6);
		chk(sel_active[1:0] === 2'h3, "pair 0 not selected");
		cmd_n[1:0] = 2'h2;
		wt(6);
		chk(sel_active[1:0] === 2'h3, "pair 0 dropped on one high line");
		cmd_n[1:0] = 2'h3;
		wt(6);
		chk(sel_active[1:0] === 2'h0, "pair 0 not deselected");
	endtask
	task automatic t_single;
		cmd_n[3:0] = 4'h8;
		for (int i = 0; i < 10 && sel_active[0] !== 1'b1; i++) wt(1);
		chk(sel_active[2] === 1'b0, "single input as fast as dual");
		wt(3);
		chk(sel_active[3:0] === 4'h7, "single inputs not independent");
		wt(TOL + 10);
		chk(pair_fault[1] === 1'b0, "single pair watched for discrepancy");
		cmd_n = 16'hffff;
		wt(6);
	endtask
	task automatic t_pairs;
		for (int g = 0; g < 8; g++) begin
			cmd_n = ~(16'h0003 << (2 * g));
			wt(6);
			chk(sel_active === (16'h0003 << (2 * g)), "pair selection wrong");
		end
		cmd_n = 16'hffff;
		wt(6);
	endtask
	task automatic t_fault;
		ack_request = 1'b1;
		cmd_n[1:0] = 2'h2;
		wt(TOL - 5);
		cmd_n[1:0] = 2'h3;
		wt(2);
		cmd_n[1:0] = 2'h2;
		wt(TOL - 5);
		chk(pair_fault[0] === 1'b0, "fault inside tolerance");
		for (int i = 0; i < TOL && pair_fault[0] !== 1'b1; i++) wt(1);
		chk(pair_fault[0] === 1'b1 && local_io_fault_message === 1'b1, "no fault");
		chk(sel_active[1:0] === 2'h3 && zone_acknowledge === 2'h0, "fault not safe");
		err_clear = 1'b1;
		wt(3);
		chk(pair_fault[0] === 1'b1, "fault cleared during mismatch");
		cmd_n[1:0] = 2'h3;
		wt(6);
		chk(pair_fault[0] === 1'b0 && local_io_fault_message === 1'b0, "fault kept");
		err_clear = 1'b0;
		wt(4);
		chk(sel_active[1:0] === 2'h0 && zone_acknowledge === 2'h3, "no recovery");
	endtask
	task automatic t_axis;
		axis_count = 6'h23;
		wt(4);
		chk(axis_overflow === 1'b0 && zone_acknowledge === 2'h3, "35 axes refused");
		axis_count = 6'h24;
		wt(4);
		chk(axis_overflow === 1'b1 && zone_acknowledge === 2'h0, "36 axes taken");
		axis_count = 6'h01;
		ack_request = 1'b0;
		wt(4);
		chk(zone_acknowledge === 2'h0, "acknowledge without request");
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			$display("mismatch at %0t: run took too long", $time);
			wrap_up();
		end
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		#1;
		chk(sel_active === 16'hffff && pair_fault === 8'h00 && zone_acknowledge === 2'h0, "reset");
		resetn = 1'b1;
		wt(4);
		t_dual();
		t_single();
		t_pairs();
		t_fault();
		t_axis();
		wrap_up();
	end
endmodule // discrete_safe_selection_inputs_tb_top
`default_nettype wire

// [safe_sel_inputs.sv]
// Purpose: Evaluates discrete safe selection inputs of one safety zone
// Assumes: Inputs synchronous to ref_clk; mode bits static during operation
// Notes: Selection and acknowledge outputs are registered
`timescale 1ns/1ps
`default_nettype none
`include "safe_sel_params.svh"
// Notes on behaviour
// [R1] A dual-channel pair samples both inputs and merges them into one safe selection.
// [R2] A single-channel input gives its own selection from that one input alone.
// [R3] A mode bit per pair picks one dual-channel input or two single-channel inputs.
// [R4] Both inputs low means the function is selected.
// [R5] The function is deselected only when both inputs are high.
// [R6] Inputs of a dual pair may disagree for up to one second, longer is a fault.
// [R7] The zone has eight pairs, i.e. sixteen inputs.
// [R8] A zone serves at most thirty-five axes.
// [R9] The external source dynamizes each channel of a dual pair separately; sel_source_model only passes static levels on, with no dynamization.
// [R10] Single-channel evaluation may react later than dual-channel evaluation.
// [R11] External wiring keeps lines on the same dynamization source from shorting.
// [R12] A state is acknowledged only with both outputs of a pair high.
// [R13] On discrepancy timeout an error latches and forces selection until cleared.
// [R14] The discrepancy timer restarts on equal levels and counts only while they differ.
module safe_sel_inputs #(
	parameter logic [`SEL_TMR_W-1:0] TOL_CYCLES = `SEL_TMR_W'(`SEL_TOL_CYCLES)
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire safe_sel_pkg::input_vec_t sel_in_n,
	input wire safe_sel_pkg::pair_vec_t pair_single,
	input wire logic err_clear,
	input wire logic [`SEL_AXIS_W-1:0] axis_count,
	input wire logic ack_request,
	output safe_sel_pkg::input_vec_t sel_active,
	output safe_sel_pkg::pair_vec_t pair_fault,
	output logic local_io_fault_message,
	output logic axis_overflow,
	output logic [1:0] zone_acknowledge
);
	safe_sel_pkg::input_vec_t in_reg, single_reg, sel_reg, sel_next;
	safe_sel_pkg::pair_vec_t fault_reg, mon_fault, dual_hold_reg, dual_sel;
	logic err_reg, ovf_reg;
	logic [1:0] ack_reg;

	// Dual pair merge: low on both selects, high on both deselects, else hold
	function automatic logic merge_pair(input logic a_n, input logic b_n, input logic prev);
		if (!a_n && !b_n) begin
			merge_pair = 1'b1; // [R4]
		end else if (a_n && b_n) begin
			merge_pair = 1'b0; // [R5]
		end else begin
			merge_pair = prev;
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < `SEL_PAIRS; g++) begin : g_pair // [R7]
			sel_pair_monitor #(.TOL_CYCLES(TOL_CYCLES)) u_mon (
				.ref_clk(ref_clk),
				.resetn(resetn),
				.enable(!pair_single[g]),
				.in_a_n(in_reg[2*g]),
				.in_b_n(in_reg[2*g+1]),
				.err_clear(err_clear),
				.fault(mon_fault[g])
			);
			assign dual_sel[g] = merge_pair(in_reg[2*g], in_reg[2*g+1], dual_hold_reg[g]); // [R1]
			// A latched fault forces the safe (selected) state
			assign sel_next[2*g] = pair_single[g] ? !single_reg[2*g] // [R3] [R2]
				: (dual_sel[g] || mon_fault[g]); // [R13]
			assign sel_next[2*g+1] = pair_single[g] ? !single_reg[2*g+1] // [R2]
				: (dual_sel[g] || mon_fault[g]);
		end
	endgenerate

	wire logic ovf_next = (axis_count > `SEL_AXIS_W'(`SEL_MAX_AXES)); // [R8]
	// Acknowledge is a both-high pair; any fault drops both outputs
	wire logic ack_next = ack_request && !(|mon_fault) && !ovf_next; // [R12]

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			in_reg <= '1;
			single_reg <= '1;
			dual_hold_reg <= '1;
			sel_reg <= '1;
			fault_reg <= '0;
			err_reg <= 1'b0;
			ovf_reg <= 1'b0;
			ack_reg <= 2'h0;
		end else begin
			in_reg <= sel_in_n; // [R1]
			// Extra register stage on the single path adds one cycle of latency; the sample is not filtered
			single_reg <= in_reg; // [R10]
			dual_hold_reg <= dual_sel;
			sel_reg <= sel_next;
			fault_reg <= mon_fault;
			err_reg <= |mon_fault; // [R13]
			ovf_reg <= ovf_next;
			ack_reg <= {ack_next, ack_next}; // [R12]
		end
	end

	assign sel_active = sel_reg;
	assign pair_fault = fault_reg;
	assign local_io_fault_message = err_reg;
	assign axis_overflow = ovf_reg;
	assign zone_acknowledge = ack_reg;

	sequence s_both_low(int i);
		!in_reg[2*i] && !in_reg[2*i+1];
	endsequence

	property p_dual_select;
		@(posedge ref_clk) disable iff (!resetn)
		(!pair_single[0] and s_both_low(0)) |=> sel_active[0] && sel_active[1];
	endproperty
	a_dual_select: assert property (p_dual_select) else $error("pair not selected"); // [R4]

	property p_dual_deselect;
		@(posedge ref_clk) disable iff (!resetn)
		!pair_single[0] && in_reg[0] && in_reg[1] && !mon_fault[0] |=> !sel_active[0];
	endproperty
	a_dual_deselect: assert property (p_dual_deselect) else $error("pair not deselected"); // [R5]

	property p_dual_hold;
		@(posedge ref_clk) disable iff (!resetn)
		!pair_single[0] && (in_reg[0] != in_reg[1]) && !mon_fault[0]
			|=> sel_active[0] == $past(dual_hold_reg[0]);
	endproperty
	a_dual_hold: assert property (p_dual_hold) else $error("mismatch changed selection"); // [R1]

	property p_single_path;
		@(posedge ref_clk) disable iff (!resetn)
		pair_single[1] ##1 pair_single[1] |=> sel_active[3] == !$past(in_reg[3], 2);
	endproperty
	a_single_path: assert property (p_single_path) else $error("single input mismatch"); // [R2]

	property p_fault_forces;
		@(posedge ref_clk) disable iff (!resetn)
		!pair_single[0] && mon_fault[0] |=> sel_active[0] && local_io_fault_message;
	endproperty
	a_fault_forces: assert property (p_fault_forces) else $error("fault did not force"); // [R13]

	property p_ack_pair;
		@(posedge ref_clk) disable iff (!resetn)
		zone_acknowledge[0] == zone_acknowledge[1];
	endproperty
	a_ack_pair: assert property (p_ack_pair) else $error("ack outputs split"); // [R12]

	property p_ack_fault;
		@(posedge ref_clk) disable iff (!resetn)
		(|mon_fault) |=> zone_acknowledge == 2'h0;
	endproperty
	a_ack_fault: assert property (p_ack_fault) else $error("ack during fault"); // [R12]

	property p_axis_limit;
		@(posedge ref_clk) disable iff (!resetn)
		axis_count > `SEL_AXIS_W'(`SEL_MAX_AXES) |=> axis_overflow;
	endproperty
	a_axis_limit: assert property (p_axis_limit) else $error("axis limit missed"); // [R8]

	// Pair 0 stands for the dual pairs and pair 1 for the single pairs
	property p_single_a;
		@(posedge ref_clk) disable iff (!resetn)
		pair_single[1] ##1 pair_single[1] |=> sel_active[2] == !$past(in_reg[2], 2);
	endproperty
	a_single_a: assert property (p_single_a) else $error("single input A mismatch"); // [R2]

	property p_single_quiet;
		@(posedge ref_clk) disable iff (!resetn)
		pair_single[1] && !mon_fault[1] |=> !mon_fault[1];
	endproperty
	a_single_quiet: assert property (p_single_quiet) else $error("single pair fault"); // [R3]

	property p_dual_same;
		@(posedge ref_clk) disable iff (!resetn)
		!pair_single[0] |=> sel_active[0] == sel_active[1];
	endproperty
	a_dual_same: assert property (p_dual_same) else $error("dual outputs split"); // [R1]

	sequence s_mismatch_begins;
		((in_reg[0] == in_reg[1]) && !mon_fault[0]) ##1 (in_reg[0] != in_reg[1]);
	endsequence

	property p_no_early;
		@(posedge ref_clk) disable iff (!resetn)
		(!pair_single[0] and s_mismatch_begins) |=> !mon_fault[0];
	endproperty
	a_no_early: assert property (p_no_early) else $error("fault without tolerance"); // [R6]

	sequence s_clear_taken;
		mon_fault[0] && err_clear && (in_reg[0] == in_reg[1]);
	endsequence

	property p_fault_clear;
		@(posedge ref_clk) disable iff (!resetn)
		(!pair_single[0] and s_clear_taken) |=> !mon_fault[0] ##1 !pair_fault[0];
	endproperty
	a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared"); // [R13]

	property p_fault_held;
		@(posedge ref_clk) disable iff (!resetn)
		!pair_single[0] && mon_fault[0] && (in_reg[0] != in_reg[1]) |=> mon_fault[0];
	endproperty
	a_fault_held: assert property (p_fault_held) else $error("fault dropped early"); // [R13]

	property p_err_flag;
		@(posedge ref_clk) disable iff (!resetn)
		local_io_fault_message == (|pair_fault);
	endproperty
	a_err_flag: assert property (p_err_flag) else $error("error flag wrong"); // [R13]

	property p_ack_given;
		@(posedge ref_clk) disable iff (!resetn)
		ack_request && !(|mon_fault) && (axis_count <= `SEL_AXIS_W'(`SEL_MAX_AXES))
			|=> zone_acknowledge == 2'h3;
	endproperty
	a_ack_given: assert property (p_ack_given) else $error("ack not given"); // [R12]

	property p_ack_idle;
		@(posedge ref_clk) disable iff (!resetn)
		!ack_request |=> zone_acknowledge == 2'h0;
	endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("ack without request"); // [R12]

	property p_axis_ok;
		@(posedge ref_clk) disable iff (!resetn)
		axis_count <= `SEL_AXIS_W'(`SEL_MAX_AXES) |=> !axis_overflow;
	endproperty
	a_axis_ok: assert property (p_axis_ok) else $error("axis count refused"); // [R8]
endmodule // safe_sel_inputs
`default_nettype wire

// [safe_sel_params.svh]
// Purpose: Constants for the discrete safe selection input block
// Assumes: 125 MHz ref_clk
// Notes: Times in their own unit, cycle counts derived from them
`ifndef SAFE_SEL_PARAMS_SVH
`define SAFE_SEL_PARAMS_SVH
`define SEL_PAIRS 8
`define SEL_INPUTS 16
`define SEL_MAX_AXES 35
`define SEL_AXIS_W 6
`define SEL_CLK_MHZ 125
`define SEL_TOL_MS 1000
// Longest time rounds down; 125e6 cycles
`define SEL_TOL_CYCLES ((`SEL_TOL_MS) * 1000 * (`SEL_CLK_MHZ))
`define SEL_TMR_W 27
// Single-channel path gets one extra register stage, so it reacts a cycle later
`define SEL_SINGLE_EXTRA 1
`endif

// [safe_sel_pkg.sv]
// Purpose: Types shared by the selection block
// Assumes: safe_sel_params.svh present
// Notes: Types only; numbers live in the header
`default_nettype none
`include "safe_sel_params.svh"
package safe_sel_pkg;
	typedef logic [`SEL_PAIRS-1:0] pair_vec_t;
	typedef logic [`SEL_INPUTS-1:0] input_vec_t;
	typedef enum logic {PAIR_DUAL, PAIR_SINGLE} pair_mode_e;
	typedef enum logic [1:0] {CH_EQUAL, CH_DIFFER, CH_FAULT} ch_state_e;
	typedef struct packed {
		logic sel_n;
		logic err;
	} pair_status_s;
endpackage
`default_nettype wire

// [sel_pair_monitor.sv]
// Purpose: Discrepancy watch for one dual-channel input pair
// Assumes: Inputs already synchronous to ref_clk
// Notes: Timer length is a parameter so simulation can shorten it
`timescale 1ns/1ps
`default_nettype none
`include "safe_sel_params.svh"
module sel_pair_monitor #(
	parameter logic [`SEL_TMR_W-1:0] TOL_CYCLES = `SEL_TMR_W'(`SEL_TOL_CYCLES)
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic enable,
	input wire logic in_a_n,
	input wire logic in_b_n,
	input wire logic err_clear,
	output logic fault
);
	safe_sel_pkg::ch_state_e state_reg, state_next;
	logic [`SEL_TMR_W-1:0] tmr_reg, tmr_next;
	wire logic differ = enable && (in_a_n != in_b_n);
	wire logic expired = (tmr_reg >= TOL_CYCLES - `SEL_TMR_W'(1));

	always_comb begin
		state_next = state_reg;
		tmr_next = tmr_reg;
		case (state_reg)
			safe_sel_pkg::CH_EQUAL: begin
				tmr_next = '0; // [R14]
				if (differ) begin
					state_next = safe_sel_pkg::CH_DIFFER;
				end
			end
			safe_sel_pkg::CH_DIFFER: begin
				if (!differ) begin
					state_next = safe_sel_pkg::CH_EQUAL; // [R14]
					tmr_next = '0;
				end else if (expired) begin
					state_next = safe_sel_pkg::CH_FAULT; // [R6]
				end else begin
					tmr_next = tmr_reg + `SEL_TMR_W'(1); // [R14]
				end
			end
			safe_sel_pkg::CH_FAULT: begin
				tmr_next = '0;
				// Clear only takes once the pair agrees, so a live fault re-arms
				if (err_clear && !differ) begin
					state_next = safe_sel_pkg::CH_EQUAL; // [R13]
				end
			end
			default: begin
				state_next = safe_sel_pkg::CH_FAULT;
				tmr_next = '0;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= safe_sel_pkg::CH_EQUAL;
			tmr_reg <= '0;
		end else begin
			state_reg <= state_next;
			tmr_reg <= tmr_next;
		end
	end

	assign fault = (state_reg == safe_sel_pkg::CH_FAULT);

	property p_timer_restart;
		@(posedge ref_clk) disable iff (!resetn)
		!differ |=> (tmr_reg == '0);
	endproperty
	a_timer_restart: assert property (p_timer_restart) else $error("timer not restarted"); // [R14]

	property p_fault_on_expiry;
		@(posedge ref_clk) disable iff (!resetn)
		(state_reg == safe_sel_pkg::CH_DIFFER) && differ && expired |=> fault;
	endproperty
	a_fault_on_expiry: assert property (p_fault_on_expiry) else $error("no fault at expiry"); // [R6]
endmodule // sel_pair_monitor
`default_nettype wire

// [sel_source_model.sv]
// Purpose: Model of the external safety unit that drives the selection lines
// Assumes: The bench hands over line levels as commands in ref_clk cycles
// Notes: Lines idle high (nothing selected); each line has its own driver bit
`timescale 1ns/1ps
`default_nettype none
module sel_source_model (
	input wire logic ref_clk,
	input wire safe_sel_pkg::input_vec_t cmd_n,
	output var safe_sel_pkg::input_vec_t sel_in_n
);
	initial sel_in_n = 16'hffff;
	// One register bit per channel, so the two channels of a pair never share a source
	// Command is taken at the edge and shows 1 ns later, so a bench write
	// in that same step never races the model
	always @(posedge ref_clk) begin
		sel_in_n <= #1 cmd_n;
	end
endmodule // sel_source_model
`default_nettype wire
